// [rtb_pkg.sv]
/*
  rtb_pkg: constants, register map and state type for the record transfer
  buffer engine. Assumes a 125 MHz core clock and a 32-bit Avalon-MM slave.
*/
// Behaviour
// - with overwrite guard on, never write a buffer until software returns it
// - each buffer is written at its own programmed target bus address
// - interleaved layout: per index, channels back-to-back at own offsets
// - ring count 2..max is active; 0 (default) disables the channel
// - nonzero flush timer ejects partial buffer after timeout; zero disables
// - per-channel setting allows one record to span several buffers
// - drop-when-full off: stop acquiring once on-board memory is full
// - drop-when-full on: discard records once a whole record no longer fits
// - fill markers are written to fixed slots at 0x80000000 plus four times the buffer index
// - 32-bit marker starts at zero, becomes 1, then increments per posted buffer
// - after overflow in drop mode, resume once free space reaches hysteresis
package rtb_pkg;
  localparam int RTB_MAX_BUFS = 16;
  localparam int RTB_AW = 8;
  // register byte offsets
  localparam logic [7:0] RTB_CTRL = 8'h00;
  localparam logic [7:0] RTB_NBUF = 8'h04;
  localparam logic [7:0] RTB_TIMER = 8'h08;
  localparam logic [7:0] RTB_STAT = 8'h0c;
  localparam logic [7:0] RTB_IRQ_ST = 8'h10;
  localparam logic [7:0] RTB_IRQ_MSK = 8'h14;
  localparam logic [7:0] RTB_RETURN = 8'h18;
  localparam logic [7:0] RTB_PK_OFS = 8'h1c;
  localparam logic [7:0] RTB_HYST = 8'h20;
  localparam logic [7:0] RTB_ADDR_BASE = 8'h40;
  localparam logic [7:0] RTB_MARK_BASE = 8'h80;
  // control fields
  localparam int RTB_C_GUARD = 0;
  localparam int RTB_C_PACK = 1;
  localparam int RTB_C_UNBND = 2;
  localparam int RTB_C_DROP = 3;
  localparam int RTB_C_HOSTALLOC = 4;
  localparam logic [31:0] RTB_CTRL_RST = 32'h0000_0011;
  localparam logic [31:0] RTB_HYST_RST = 32'h0000_0003;
  // flush timer step: 65536 sample-clock units of 8 periods
  localparam int RTB_STEP_SAMPLES = 65536 * 8;
  localparam int RTB_CORE_MHZ = 125;
  localparam int RTB_STEP_CYC = RTB_STEP_SAMPLES;
  // interrupt bits
  localparam int RTB_I_DONE = 0;
  localparam int RTB_I_OVF = 1;
  localparam int RTB_I_FLUSH = 2;
  typedef enum logic [2:0] {
    RTB_IDLE, RTB_DATA, RTB_MARK, RTB_WAITB
  } rtb_state_e;
endpackage

// [rtb_addr_mem.sv]
/*
  rtb_addr_mem: small table of per-buffer target addresses with a
  registered read port. Assumes writer and reader share the core clock.
*/
`timescale 1ns/1ps
module rtb_addr_mem import rtb_pkg::*; #(
  parameter int DEPTH = RTB_MAX_BUFS,
  parameter int AW = 4
) (
  input wire logic core_clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [AW-1:0] rd_idx_in,
  output logic [31:0] rd_data_out
);
  logic [31:0] mem_q [DEPTH];
  // write port and registered read
  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_idx_in];
  end
endmodule

// [rtb_dma_engine.sv]
/*
  rtb_dma_engine: one channel of the record transfer engine. Moves record
  words into a ring of target buffers over a simple write master and posts
  fill markers. Assumes a 125 MHz core clock, synchronous active-high reset
  and a DMA write port that accepts a word when ready is high.
*/
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module rtb_dma_engine import rtb_pkg::*; #(
  parameter int NBUF_MAX = RTB_MAX_BUFS,
  parameter int BUF_WORDS = 64,
  parameter int STEP_CYC = RTB_STEP_CYC,
  parameter int MEM_WORDS = 1024
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [RTB_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // record source from acquisition
  input wire logic rec_valid_in,
  input wire logic [31:0] rec_data_in,
  input wire logic rec_last_in,
  output logic rec_ready_out,
  // on-board memory fill level in words
  input wire logic [15:0] mem_level_in,
  input wire logic [15:0] rec_words_in,
  output logic acq_stop_out,
  // dma write master
  output logic dma_valid_out,
  output logic [31:0] dma_addr_out,
  output logic [31:0] dma_data_out,
  input wire logic dma_ready_in,
  output logic irq_out
);
  localparam int IW = $clog2(NBUF_MAX);
  logic [31:0] ctrl_q, ctrl_d, nbuf_q, nbuf_d, timer_q, timer_d;
  logic [31:0] ofs_q, ofs_d, hyst_q, hyst_d;
  logic [2:0] ist_q, ist_d, msk_q, msk_d;
  logic [NBUF_MAX-1:0] busy_q, busy_d;
  logic [31:0] mark_q [NBUF_MAX];
  logic [31:0] mark_d [NBUF_MAX];
  rtb_state_e st_q, st_d;
  logic [IW-1:0] idx_q, idx_d;
  logic [15:0] fill_q, fill_d;
  logic [31:0] tcnt_q, tcnt_d;
  logic [15:0] steps_q, steps_d;
  logic drop_q, drop_d, stop_q, stop_d, ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [31:0] base_addr;
  logic active, wr_hit, addr_wr, mark_wr;
  logic [2:0] ev;
  logic flush_due, take;
  logic [16:0] need_words;
  // all checks below sample on the core clock, quiet in reset
  default clocking cb_core @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // buffer address table
  assign addr_wr = avs_write_in && ack_q &&
    avs_address_in[7:6] == RTB_ADDR_BASE[7:6];
  rtb_addr_mem #(.DEPTH(NBUF_MAX), .AW(IW)) u_addr (
    .core_clk_in(core_clk_in),
    .wr_en_in(addr_wr),
    .wr_idx_in(avs_address_in[IW+1:2]),
    .wr_data_in(avs_writedata_in),
    .rd_idx_in(idx_d),
    .rd_data_out(base_addr)
  );

  // channel active only with ring count in range
  assign active = nbuf_q >= 32'd2 && nbuf_q <= NBUF_MAX;
  assign wr_hit = avs_write_in && ack_q; // lands as waitrequest drops
  assign flush_due = timer_q != 32'd0 && steps_q >= timer_q[15:0];
  assign take = st_q == RTB_DATA && active && rec_valid_in && !drop_q &&
    dma_ready_in;

  // room check in 17 bits so a large record cannot wrap the sum
  assign need_words = {1'b0, mem_level_in} + {1'b0, rec_words_in};

  // overflow and drop control
  always_comb begin
    stop_d = stop_q;
    drop_d = drop_q;
    if (!ctrl_q[RTB_C_DROP]) begin
      if (mem_level_in >= MEM_WORDS[15:0]) stop_d = 1'b1;
    end else if (need_words > 17'(MEM_WORDS)) begin
      drop_d = 1'b1;
    end else if (drop_q && 32'(MEM_WORDS - mem_level_in) * 100 >=
                 hyst_q * MEM_WORDS && rec_valid_in == 1'b0) begin
      drop_d = 1'b0;
    end
  end

  // transfer state machine
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    fill_d = fill_q;
    busy_d = busy_q;
    ev = 3'b000;
    tcnt_d = tcnt_q;
    steps_d = steps_q;
    for (int i = 0; i < NBUF_MAX; i++) mark_d[i] = mark_q[i];
    if (wr_hit && avs_address_in == RTB_RETURN) begin
      busy_d = busy_q & ~avs_writedata_in[NBUF_MAX-1:0];
    end
    // flush step counter
    if (fill_q != 16'd0 && tcnt_q == 32'(STEP_CYC - 1)) begin
      tcnt_d = 32'd0;
      steps_d = steps_q + 16'd1;
    end else if (fill_q != 16'd0) begin
      tcnt_d = tcnt_q + 32'd1;
    end
    case (st_q)
      RTB_IDLE: begin
        if (active) st_d = RTB_WAITB;
      end
      RTB_WAITB: begin
        // respect guard before reuse
        if (!active) st_d = RTB_IDLE;
        else if (!(ctrl_q[RTB_C_GUARD] && busy_q[idx_q])) st_d = RTB_DATA;
      end
      RTB_DATA: begin
        if (take) begin
          fill_d = fill_q + 16'd1;
          if (rec_last_in && !ctrl_q[RTB_C_UNBND]) ev[RTB_I_DONE] = 1'b1;
        end
        // full buffer, or partial eject, or record end
        if ((take && fill_q == 16'(BUF_WORDS - 1)) || flush_due ||
            (take && rec_last_in && !ctrl_q[RTB_C_UNBND])) begin
          st_d = RTB_MARK;
          if (flush_due) ev[RTB_I_FLUSH] = 1'b1;
        end
        // a disabled ring stops even mid-buffer
        if (!active) st_d = RTB_IDLE;
      end
      RTB_MARK: begin
        if (dma_ready_in) begin
          mark_d[idx_q] = mark_q[idx_q] + 32'd1;
          busy_d[idx_q] = 1'b1;
          fill_d = 16'd0;
          tcnt_d = 32'd0;
          steps_d = 16'd0;
          idx_d = (32'(idx_q) == nbuf_q - 32'd1) ? '0 : idx_q + 1'b1;
          st_d = RTB_WAITB;
        end
      end
      default: st_d = RTB_IDLE;
    endcase
  end

  // register writes and interrupt status
  always_comb begin
    ctrl_d = ctrl_q;
    nbuf_d = nbuf_q;
    timer_d = timer_q;
    ofs_d = ofs_q;
    hyst_d = hyst_q;
    msk_d = msk_q;
    ist_d = ist_q;
    if (wr_hit) begin
      case (avs_address_in)
        RTB_CTRL: ctrl_d = avs_writedata_in;
        RTB_NBUF: nbuf_d = avs_writedata_in;
        RTB_TIMER: timer_d = avs_writedata_in;
        RTB_PK_OFS: ofs_d = avs_writedata_in;
        RTB_HYST: hyst_d = avs_writedata_in;
        RTB_IRQ_MSK: msk_d = avs_writedata_in[2:0];
        RTB_IRQ_ST: ist_d = ist_q & ~avs_writedata_in[2:0];
        default: ist_d = ist_q;
      endcase
    end
    // set wins over clear
    ist_d = ist_d | ev | {1'b0, drop_d & ~drop_q | stop_d & ~stop_q, 1'b0};
  end

  // read data mux
  always_comb begin
    rdat_d = 32'd0;
    if (avs_address_in[7:6] == RTB_MARK_BASE[7:6]) begin
      rdat_d = mark_q[avs_address_in[IW+1:2]];
    end else begin
      case (avs_address_in)
        RTB_CTRL: rdat_d = ctrl_q;
        RTB_NBUF: rdat_d = nbuf_q;
        RTB_TIMER: rdat_d = timer_q;
        RTB_STAT: rdat_d = {16'(busy_q), 8'(idx_q), 5'd0, drop_q, stop_q,
                            active};
        RTB_IRQ_ST: rdat_d = {29'd0, ist_q};
        RTB_IRQ_MSK: rdat_d = {29'd0, msk_q};
        RTB_PK_OFS: rdat_d = ofs_q;
        RTB_HYST: rdat_d = hyst_q;
        default: rdat_d = 32'd0;
      endcase
    end
  end
  // one answer cycle per request
  assign ack_d = (avs_read_in || avs_write_in) && !ack_q;

  // state registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_q <= RTB_CTRL_RST;
      nbuf_q <= 32'd0;
      timer_q <= 32'd0;
      ofs_q <= 32'd0;
      hyst_q <= RTB_HYST_RST;
      msk_q <= 3'd0;
      ist_q <= 3'd0;
      busy_q <= '0;
      st_q <= RTB_IDLE;
      idx_q <= '0;
      fill_q <= 16'd0;
      tcnt_q <= 32'd0;
      steps_q <= 16'd0;
      drop_q <= 1'b0;
      stop_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'd0;
      for (int i = 0; i < NBUF_MAX; i++) mark_q[i] <= 32'd0;
    end else begin
      ctrl_q <= ctrl_d;
      nbuf_q <= nbuf_d;
      timer_q <= timer_d;
      ofs_q <= ofs_d;
      hyst_q <= hyst_d;
      msk_q <= msk_d;
      ist_q <= ist_d;
      busy_q <= busy_d;
      st_q <= st_d;
      idx_q <= idx_d;
      fill_q <= fill_d;
      tcnt_q <= tcnt_d;
      steps_q <= steps_d;
      drop_q <= drop_d;
      stop_q <= stop_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      for (int i = 0; i < NBUF_MAX; i++) mark_q[i] <= mark_d[i];
    end
  end

  // bus answer one cycle after request
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_q;
  assign avs_readdata_out = rdat_q;
  assign irq_out = |(ist_q & msk_q);
  assign acq_stop_out = stop_q;
  assign rec_ready_out = take || (drop_q && st_q != RTB_IDLE);
  assign dma_valid_out = (st_q == RTB_DATA && active && rec_valid_in &&
                          !drop_q) || st_q == RTB_MARK;
  // target address: buffer base plus packed offset plus word position, or marker slot
  assign dma_addr_out = st_q == RTB_MARK ?
    {RTB_MARK_BASE, 24'(idx_q) << 2} :
    base_addr + (ctrl_q[RTB_C_PACK] ? ofs_q : 32'd0) +
    {14'd0, fill_q, 2'b00};
  assign dma_data_out = st_q == RTB_MARK ? mark_q[idx_q] + 32'd1 :
                        rec_data_in;

  // guarded buffer is never written
  guard_hold_a: assert property (
    st_q == RTB_WAITB && ctrl_q[RTB_C_GUARD] && busy_q[idx_q]
      |=> st_q != RTB_DATA) else $error("wrote locked buffer");
  // an inactive channel moves no data
  disabled_idle_a: assert property (
    !active |-> ##1 !(st_q == RTB_DATA && take))
    else $error("inactive channel moved data");
  // steps of a buffer hand-over
  sequence mark_accept_s;
    st_q == RTB_MARK && dma_ready_in;
  endsequence
  sequence lock_taken_s;
    st_q == RTB_WAITB && busy_q[$past(idx_q)];
  endsequence
  // marker posted: its value steps by one
  marker_step_a: assert property (
    mark_accept_s |=> mark_q[$past(idx_q)] == $past(mark_q[idx_q]) + 32'd1)
    else $error("marker not incremented");
  // marker posted: buffer is locked in the next cycle
  busy_lock_a: assert property (
    mark_accept_s |=> lock_taken_s)
    else $error("buffer not locked after marker");
  // full memory stops acquisition without drop mode
  stop_full_a: assert property (
    !ctrl_q[RTB_C_DROP] && mem_level_in >= MEM_WORDS[15:0] |=> acq_stop_out)
    else $error("no stop on full");
  // ring wraps to index zero after the last buffer
  wrap_order_a: assert property (
    st_q == RTB_MARK && dma_ready_in && 32'(idx_q) == nbuf_q - 32'd1
      |=> idx_q == '0) else $error("ring did not wrap");
  // a due flush ejects the partial buffer
  flush_eject_a: assert property (
    st_q == RTB_DATA && active && flush_due |=> st_q == RTB_MARK)
    else $error("partial buffer not ejected");
  // while dropping, no record word reaches the dma port
  drop_block_a: assert property (
    drop_q |-> !(dma_valid_out && st_q == RTB_DATA))
    else $error("dropped word was written");
  // a held request is answered in the next cycle
  bus_answer_a: assert property (
    avs_waitrequest_out && (avs_read_in || avs_write_in)
      |=> !avs_waitrequest_out)
    else $error("bus request not answered");
endmodule

// [rtb_dma_sink.sv]
/*
  rtb_dma_sink: behavioural target memory behind the dma write master.
  Assumes the core clock; it stalls two cycles in every eight.
*/
`timescale 1ns/1ps
module rtb_dma_sink (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic valid_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] data_in,
  output logic ready_out,
  output logic [15:0] dcnt_out,
  output logic [31:0] daddr_out,
  output logic [31:0] ddata_out,
  output logic [15:0] mcnt_out,
  output logic [31:0] maddr_out,
  output logic [31:0] mval_out
);
  logic [2:0] tick_q;
  // stalls make the master hold its word
  assign ready_out = (tick_q > 3'h1);
  // log accepted words, markers apart from data
  always_ff @(posedge core_clk_in) begin
    tick_q <= rst_in ? 3'h0 : tick_q + 3'h1;
    if (rst_in) begin
      dcnt_out <= 16'h0;
      mcnt_out <= 16'h0;
    end else if (valid_in && ready_out && addr_in[31]) begin
      mcnt_out <= mcnt_out + 16'h1;
      maddr_out <= addr_in;
      mval_out <= data_in;
    end else if (valid_in && ready_out) begin
      dcnt_out <= dcnt_out + 16'h1;
      daddr_out <= addr_in;
      ddata_out <= data_in;
    end
  end
endmodule

// [rtb_dma_engine_bench.sv]
/*
  rtb_dma_engine_bench: self-checking bench for one transfer channel.
  Assumes four-word buffers and a 16-cycle flush step.
*/
`timescale 1ns/1ps
module rtb_dma_engine_bench import rtb_pkg::*; ;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0, rec_valid_in = 1'b0;
  logic rec_last_in = 1'b0;
  logic [RTB_AW-1:0] avs_address_in = 8'h00;
  logic [31:0] avs_writedata_in = 32'h0, rec_data_in = 32'h0;
  logic [15:0] mem_level_in = 16'h0;
  logic [31:0] avs_readdata_out, dma_addr_out, dma_data_out;
  logic avs_waitrequest_out, rec_ready_out, acq_stop_out, dma_valid_out;
  logic dma_ready_in, irq_out;
  logic [15:0] dcnt, mcnt;
  logic [31:0] daddr, ddata, maddr, mval, rd;
  logic [31:0] seed = 32'hdd41;
  int bad_count = 0, checks = 0;

  // four-word buffers, whole records, no external flush
  rtb_dma_engine #(.BUF_WORDS(4), .STEP_CYC(16)) i_rtb_dma_engine (
    .core_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .rec_valid_in, .rec_data_in, .rec_last_in, .rec_ready_out,
    .mem_level_in, .rec_words_in(16'h0004), .acq_stop_out, .dma_valid_out,
    .dma_addr_out, .dma_data_out, .dma_ready_in, .irq_out);
  rtb_dma_sink i_rtb_dma_sink (.core_clk_in, .rst_in,
    .valid_in(dma_valid_out), .addr_in(dma_addr_out),
    .data_in(dma_data_out), .ready_out(dma_ready_in), .dcnt_out(dcnt),
    .daddr_out(daddr), .ddata_out(ddata), .mcnt_out(mcnt),
    .maddr_out(maddr), .mval_out(mval));

  // 125 MHz core clock
  initial begin
    forever #4 core_clk_in = ~core_clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic stop_run();
    bad_count++;
    summarize();
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    if (n == 50) stop_run();
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  // one random record word, then its dma write
  task automatic put(input logic [31:0] exp_a, input logic last);
    int n;
    logic [15:0] c0;
    @(posedge core_clk_in);
    seed = xs(seed);
    c0 = dcnt;
    rec_data_in <= seed;
    rec_last_in <= last;
    rec_valid_in <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_in);
      if (rec_ready_out === 1'b1) break;
    end
    if (n == 50) stop_run();
    rec_valid_in <= 1'b0;
    rec_last_in <= 1'b0;
    for (n = 0; n < 50 && dcnt == c0; n++) @(posedge core_clk_in);
    if (dcnt == c0) stop_run();
    check("dma addr", daddr, exp_a);
    check("dma data", ddata, seed);
  endtask
  // nw words into buffer idx, then its marker
  task automatic fill(input logic [31:0] base, idx, nw, mexp, lastk);
    int k;
    logic [15:0] m0;
    m0 = mcnt;
    for (k = 0; k < nw; k++) put(base + 32'(4 * k), 32'(k) == lastk);
    for (k = 0; k < 200 && mcnt == m0; k++) @(posedge core_clk_in);
    if (mcnt == m0) stop_run();
    check("marker addr", maddr, 32'h8000_0000 | (idx << 2));
    check("marker value", mval, mexp);
  endtask
  // offered words must not reach the dma port
  task automatic stalled();
    logic [15:0] c0;
    c0 = dcnt;
    @(posedge core_clk_in);
    rec_valid_in <= 1'b1;
    repeat (30) @(posedge core_clk_in);
    rec_valid_in <= 1'b0;
    check("held off", {16'h0, dcnt}, {16'h0, c0});
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    bus(0, RTB_CTRL, 0);
    check("ctrl", rd, RTB_CTRL_RST);
    bus(0, RTB_HYST, 0);
    check("hyst", rd, RTB_HYST_RST);
    bus(0, RTB_NBUF, 0);
    check("nbuf", rd, 32'h0);
    bus(0, 8'hfc, 0);
    check("unmapped", rd, 32'h0);
    stalled();
    bus(1, RTB_ADDR_BASE, 32'h1000);
    bus(1, RTB_ADDR_BASE + 8'h04, 32'h2000);
    bus(1, RTB_NBUF, 32'h2);
    fill(32'h1000, 0, 4, 1, 3);
    bus(0, RTB_IRQ_ST, 0);
    check("done bit", rd & 32'h1, 32'h1);
    check("masked irq", {31'h0, irq_out}, 32'h0);
    bus(1, RTB_IRQ_MSK, 32'h1);
    @(posedge core_clk_in);
    check("irq", {31'h0, irq_out}, 32'h1);
    fill(32'h2000, 1, 4, 1, 3);
    stalled();
    bus(1, RTB_RETURN, 32'h1);
    fill(32'h1000, 0, 4, 2, 3);
    bus(0, RTB_MARK_BASE, 0);
    check("marker reg", rd, 32'h2);
    bus(1, RTB_RETURN, 32'h2);
    bus(1, RTB_TIMER, 32'h1);
    fill(32'h2000, 1, 1, 2, 9);
    bus(1, RTB_IRQ_ST, 32'h7);
    @(posedge core_clk_in);
    check("irq clear", {31'h0, irq_out}, 32'h0);
    mem_level_in <= 16'd1024;
    repeat (4) @(posedge core_clk_in);
    check("acq stop", {31'h0, acq_stop_out}, 32'h1);
    // mid-run reset, then a packed, unbounded, drop-when-full channel
    mem_level_in <= 16'd0;
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    bus(1, RTB_ADDR_BASE, 32'h3000);
    bus(1, RTB_PK_OFS, 32'h100);
    bus(1, RTB_CTRL, 32'h1f);
    bus(1, RTB_NBUF, 32'h2);
    mem_level_in <= 16'd1022;
    stalled();
    mem_level_in <= 16'd1000;
    repeat (4) @(posedge core_clk_in);
    bus(0, RTB_STAT, 0);
    check("drop held", rd & 32'h4, 32'h4);
    mem_level_in <= 16'd990;
    repeat (4) @(posedge core_clk_in);
    bus(0, RTB_STAT, 0);
    check("drop ended", rd & 32'h4, 32'h0);
    fill(32'h3100, 0, 4, 1, 0);
    bus(0, RTB_IRQ_ST, 0);
    check("ovf no done", rd & 32'h3, 32'h2);
    summarize();
  end
endmodule
